/* File: rtl/sfm_map.svh */
/*
 * Constants of the serial port: word and buffer sizes, clock timing.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH

`define SFM_WORD_BITS        8
`define SFM_FIFO_DEPTH       32
`define SFM_DIV_BITS         8
`define SFM_CLK_PERIOD_PS    8000
`define SFM_SCK_MIN_PERIOD_PS 66700
// least half period of the serial clock, rounded up to whole cycles
`define SFM_HALF_MIN_CYC \
    ((`SFM_SCK_MIN_PERIOD_PS + 2 * `SFM_CLK_PERIOD_PS - 1) / (2 * `SFM_CLK_PERIOD_PS))

`endif

/* File: rtl/sfm_pkg.sv */
/*
 * Types shared by the serial port design.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfm_pkg;
    typedef enum logic [0:0] {
        SFM_IDLE  = 1'b0,
        SFM_SHIFT = 1'b1
    } sfm_state_e;
endpackage

/* File: rtl/sfm_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides and registered flags.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module sfm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // draining side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            in_ready  <= (next_count != CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign out_data = mem[rd_ptr];
endmodule // sfm_fifo

/* File: rtl/sfm_top.sv */
/*
 * Serial peripheral port: master or slave, optional framed operation,
 * transmit FIFO feeding a one-word transmit buffer and the shift register.
 * Assumes control bits are steady from clk's domain; pins are asynchronous.
 */
`timescale 1ns/1ns
`include "sfm_map.svh"
module sfm_top #(
    parameter int WIDTH = `SFM_WORD_BITS,
    parameter int DEPTH = `SFM_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // configuration
    input  wire logic                     port_enable,
    input  wire logic                     master_role_enable,
    input  wire logic                     framed_operation_enable,
    input  wire logic                     select_pin_function_enable,
    input  wire logic                     input_sample_phase,
    input  wire logic                     frame_sync_polarity,
    input  wire logic                     clock_idle_polarity,
    input  wire logic [`SFM_DIV_BITS-1:0] clk_half_div,
    // transmit stream
    input  wire logic [WIDTH-1:0]         tx_data,
    input  wire logic                     tx_valid,
    output logic                          tx_ready,
    // received words
    output logic      [WIDTH-1:0]         rx_data,
    output logic                          rx_valid,
    // status
    output logic                          tx_buffer_full,
    output logic                          busy,
    output logic                          config_error,
    output logic                          tx_underrun,
    // pins
    input  wire logic                     serial_clock_pin_in,
    output logic                          serial_clock_pin_out,
    output logic                          serial_clock_pin_oe,
    input  wire logic                     slave_select_pin_in,
    output logic                          slave_select_pin_out,
    output logic                          slave_select_pin_oe,
    input  wire logic                     sdi,
    output logic                          sdo,
    output logic                          sdo_oe
);
    localparam int DW = `SFM_DIV_BITS;
    localparam int HALF_MIN_INT = `SFM_HALF_MIN_CYC;
    localparam logic [DW-1:0] HALF_MIN = DW'(HALF_MIN_INT);
    localparam int CNTW = $clog2(WIDTH);
    // transmit FIFO into the one-word buffer
    logic [WIDTH-1:0] fifo_data;
    logic             fifo_valid;
    logic             fifo_ready;
    sfm_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );
    // pin synchronisers: first stage read only by the second
    logic sck_m, sck_s, sck_p;
    logic ss_m, ss_s;
    logic sdi_m, sdi_s;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // idle level, so no false edge follows reset
            sck_m <= clock_idle_polarity;
            sck_s <= clock_idle_polarity;
            sck_p <= clock_idle_polarity;
            ss_m  <= 1'b1;
            ss_s  <= 1'b1;
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
        end else begin
            sck_m <= serial_clock_pin_in;
            sck_s <= sck_m;
            sck_p <= sck_s;
            ss_m  <= slave_select_pin_in;
            ss_s  <= ss_m;
            sdi_m <= sdi;
            sdi_s <= sdi_m;
        end
    end
    // engine state
    sfm_pkg::sfm_state_e state, next_state;
    logic [WIDTH-1:0] buf_q, next_buf_q;
    logic             next_buf_full;
    logic [WIDTH-1:0] sh, next_sh;
    logic [WIDTH-1:0] rsh, next_rsh;
    logic [CNTW-1:0]  cnt, next_cnt;
    logic [DW-1:0]    div, next_div;
    logic             next_sck;
    logic             sync_q, next_sync_q;
    logic             smp_eff, next_smp_eff;
    logic             smp_prev;
    logic [WIDTH-1:0] next_rx_data;
    logic             next_rx_valid;
    logic             next_underrun;
    // combinational helpers
    logic             enabled;
    logic [DW-1:0]    half;
    logic             m_tick, lead, trail, sample_ev;
    logic             selected, start_ev;
    logic [WIDTH-1:0] rx_word;
    always_comb begin
        enabled   = port_enable && !config_error;
        half      = (clk_half_div < HALF_MIN) ? HALF_MIN : clk_half_div;
        m_tick    = master_role_enable && enabled && (div == '0)
                    && (framed_operation_enable || state == sfm_pkg::SFM_SHIFT);
        if (master_role_enable) begin
            lead  = m_tick && (serial_clock_pin_out == clock_idle_polarity);
            trail = m_tick && (serial_clock_pin_out != clock_idle_polarity);
        end else begin
            lead  = enabled && (sck_s != clock_idle_polarity) && (sck_p == clock_idle_polarity);
            trail = enabled && (sck_s == clock_idle_polarity) && (sck_p != clock_idle_polarity);
        end
        sample_ev = smp_eff ? trail : lead;
        selected  = !select_pin_function_enable || !ss_s;
        rx_word   = sample_ev ? {rsh[WIDTH-2:0], sdi_s} : rsh;
        next_state    = state;
        next_buf_q    = buf_q;
        next_buf_full = tx_buffer_full;
        next_sh       = sh;
        next_rsh      = rsh;
        next_cnt      = cnt;
        next_sync_q   = sync_q;
        next_rx_data  = rx_data;
        next_rx_valid = 1'b0;
        next_underrun = 1'b0;
        start_ev      = 1'b0;
        fifo_ready    = !tx_buffer_full;
        if (fifo_valid && !tx_buffer_full) begin
            next_buf_q    = fifo_data;
            next_buf_full = 1'b1;
        end
        // late sampling only when raised with or after the master enable
        next_smp_eff = master_role_enable && input_sample_phase
                       && (smp_eff || !smp_prev);
        if (!enabled) begin
            next_state  = sfm_pkg::SFM_IDLE;
            next_sync_q = 1'b0;
        end else if (state == sfm_pkg::SFM_IDLE) begin
            if (master_role_enable) begin
                start_ev = tx_buffer_full && (!framed_operation_enable || trail);
            end else if (framed_operation_enable) begin
                start_ev = lead && (ss_s == frame_sync_polarity);
            end else begin
                start_ev = lead && selected;
            end
        end else begin
            if (sample_ev) begin
                next_rsh = {rsh[WIDTH-2:0], sdi_s};
            end
            if (!master_role_enable && !framed_operation_enable && !selected) begin
                next_state = sfm_pkg::SFM_IDLE;
            end else if (trail) begin
                next_sync_q = 1'b0;
                if (cnt == CNTW'(WIDTH - 1)) begin
                    next_rx_data  = rx_word;
                    next_rx_valid = 1'b1;
                    next_state    = sfm_pkg::SFM_IDLE;
                    // framed master chains words with no idle clock
                    start_ev = master_role_enable && framed_operation_enable && tx_buffer_full;
                end else begin
                    next_cnt = cnt + 1'b1;
                    next_sh  = {sh[WIDTH-2:0], 1'b0};
                end
            end
        end

        if (start_ev) begin
            // empty slave buffer sends zeros; the far master owns the timing
            next_underrun = !tx_buffer_full;
            next_sh       = tx_buffer_full ? buf_q : '0;
            next_buf_full = 1'b0;
            next_cnt      = '0;
            next_state    = sfm_pkg::SFM_SHIFT;
            next_sync_q   = master_role_enable && framed_operation_enable;
            if (!master_role_enable) begin
                next_rsh = {rsh[WIDTH-2:0], sdi_s};
            end
        end

        if (!master_role_enable || !enabled) begin
            next_sck = clock_idle_polarity;
        end else begin
            next_sck = m_tick ? !serial_clock_pin_out : serial_clock_pin_out;
        end
        // divider restarts so a fresh word gets a full first half period
        if (!m_tick && (framed_operation_enable || state == sfm_pkg::SFM_SHIFT)
            && div != '0) begin
            next_div = div - 1'b1;
        end else begin
            next_div = half - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state                <= sfm_pkg::SFM_IDLE;
            buf_q                <= '0;
            tx_buffer_full       <= 1'b0;
            sh                   <= '0;
            rsh                  <= '0;
            cnt                  <= '0;
            div                  <= '0;
            sync_q               <= 1'b0;
            smp_eff              <= 1'b0;
            smp_prev             <= 1'b0;
            rx_data              <= '0;
            rx_valid             <= 1'b0;
            tx_underrun          <= 1'b0;
            busy                 <= 1'b0;
            config_error         <= 1'b0;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
            slave_select_pin_out <= 1'b1;
            slave_select_pin_oe  <= 1'b0;
            sdo                  <= 1'b0;
            sdo_oe               <= 1'b0;
        end else begin
            state                <= next_state;
            buf_q                <= next_buf_q;
            tx_buffer_full       <= next_buf_full;
            sh                   <= next_sh;
            rsh                  <= next_rsh;
            cnt                  <= next_cnt;
            div                  <= next_div;
            sync_q               <= next_sync_q;
            smp_eff              <= next_smp_eff;
            smp_prev             <= input_sample_phase;
            rx_data              <= next_rx_data;
            rx_valid             <= next_rx_valid;
            tx_underrun          <= next_underrun;
            busy                 <= (next_state == sfm_pkg::SFM_SHIFT);
            config_error         <= framed_operation_enable && select_pin_function_enable;
            serial_clock_pin_out <= next_sck;
            serial_clock_pin_oe  <= master_role_enable && enabled;
            slave_select_pin_out <= next_sync_q ? frame_sync_polarity : !frame_sync_polarity;
            slave_select_pin_oe  <= master_role_enable && framed_operation_enable && enabled;
            sdo                  <= (next_state == sfm_pkg::SFM_SHIFT) ? next_sh[WIDTH-1]
                                    : (next_buf_full && next_buf_q[WIDTH-1]);
            sdo_oe               <= enabled && (master_role_enable || selected);
        end
    end

    // helper: cycles since the serial clock output last changed
    logic [DW:0] since_edge;
    always_ff @(posedge clk) begin
        if (!rst_n || serial_clock_pin_out != next_sck) begin
            since_edge <= '0;
        end else if (since_edge != '1) begin
            since_edge <= since_edge + 1'b1;
        end
    end
    a_sck_half_min: assert property (@(posedge clk) disable iff (!rst_n)
        (serial_clock_pin_oe && $past(serial_clock_pin_oe) && $changed(serial_clock_pin_out)
         && $past(serial_clock_pin_oe, 2))
        |-> ($past(since_edge) + 1 >= HALF_MIN_INT))
        else $error("serial clock half period too short");
    a_clock_free_run: assert property (@(posedge clk) disable iff (!rst_n)
        (master_role_enable && framed_operation_enable && port_enable && !config_error)
        |-> ##[1:600] ($changed(serial_clock_pin_out) || !framed_operation_enable
                       || !master_role_enable || !port_enable || config_error))
        else $error("framed master clock stalled");
    a_sample_phase_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (input_sample_phase && !master_role_enable ##1 input_sample_phase && master_role_enable)
        |=> !smp_eff)
        else $error("early sample phase took effect");
    a_buffer_moves: assert property (@(posedge clk) disable iff (!rst_n)
        (start_ev && tx_buffer_full) |=> (!tx_buffer_full && busy && sh == $past(buf_q)))
        else $error("buffer not moved at transfer start");
    a_sync_marks_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (start_ev && master_role_enable && framed_operation_enable)
        |=> ##1 (slave_select_pin_out == frame_sync_polarity))
        else $error("frame start without sync pulse");
    a_sync_idle_level: assert property (@(posedge clk) disable iff (!rst_n)
        (slave_select_pin_oe && !busy && $past(!busy) && $past(!busy, 2))
        |-> (slave_select_pin_out == !frame_sync_polarity))
        else $error("sync pin not at inactive level between pulses");
    a_invalid_config: assert property (@(posedge clk) disable iff (!rst_n)
        (framed_operation_enable && select_pin_function_enable) [*2] |=> !busy)
        else $error("port ran with invalid configuration");
endmodule // sfm_top

/* File: sim/sfm_far_end.sv */
/*
 * Far-end serial device: a slave answering a master port, or a master
 * clocking a slave port at 125 ns per bit.
 * Assumes the bench routes the pins and calls load and run_word.
 */
`timescale 1ns/1ns
module sfm_far_end (
    // role, high when this end makes the clock
    input  wire logic       lead,
    // pins
    input  wire logic       sck_in,
    input  wire logic       din,
    output logic            sck_out,
    output logic            dout,
    // last word taken in
    output logic [7:0]      got
);
    logic [7:0] sh;
    time        t_last;
    time        min_half;

    initial begin
        sck_out = 1'b0;
        dout = 1'b0;
        got = 8'h00;
        sh = 8'h00;
        t_last = 0;
        min_half = 1000;
    end

    task automatic load(input logic [7:0] w);
        sh = w;
        dout = w[7];
        t_last = 0;
        min_half = 1000;
    endtask

    // slave role: sample on the leading edge, shift on the trailing edge
    always @(sck_in) begin
        if (!lead) begin
            if (t_last != 0 && $time - t_last < min_half) begin
                min_half = $time - t_last;
            end
            t_last = $time;
            if (sck_in === 1'b1) begin
                got = {got[6:0], din};
            end else begin
                // stale bits come back inverted, so a late sample never matches
                sh = {sh[6:0], ~sh[7]};
                dout = sh[7];
            end
        end
    end

    // master role: clock stands still at idle level outside the word
    task automatic run_word(input logic [7:0] w);
        for (int k = 7; k >= 0; k--) begin
            dout = w[k];
            #62 sck_out = 1'b1;
            got = {got[6:0], din};
            #63 sck_out = 1'b0;
        end
        dout = ~w[0];
    endtask
endmodule // sfm_far_end

/* File: sim/tb_spi_frame_and_master_control.sv */
/*
 * Self-checking bench of the serial port: master, framed, slave, fill and drain.
 * Assumes the design files and the far-end model are compiled first.
 */
`timescale 1ns/1ns
module tb_spi_frame_and_master_control;
    // controls
    logic       clk, rst_n, port_enable, master_role_enable, framed_operation_enable;
    logic       select_pin_function_enable, input_sample_phase, frame_sync_polarity;
    logic       clock_idle_polarity, tx_valid, ss_drv, prev;
    logic [7:0] clk_half_div, tx_data, rx_data, far_got;
    // design outputs
    logic       tx_ready, rx_valid, tx_buffer_full, busy, config_error, tx_underrun;
    logic       serial_clock_pin_out, serial_clock_pin_oe, slave_select_pin_out;
    logic       slave_select_pin_oe, sdo, sdo_oe, far_sck, sdi;
    wire        serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : far_sck;
    wire        slave_select_pin_in = slave_select_pin_oe ? slave_select_pin_out : ss_drv;
    int         error_cnt, checks_done, rx_cnt, ur_cnt, i, n, u;

    sfm_top dut (
        .clk, .rst_n, .port_enable, .master_role_enable, .framed_operation_enable,
        .select_pin_function_enable, .input_sample_phase, .frame_sync_polarity,
        .clock_idle_polarity, .clk_half_div, .tx_data, .tx_valid, .tx_ready, .rx_data,
        .rx_valid, .tx_buffer_full, .busy, .config_error, .tx_underrun,
        .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe,
        .slave_select_pin_in, .slave_select_pin_out, .slave_select_pin_oe, .sdi, .sdo,
        .sdo_oe
    );
    sfm_far_end far (
        .lead(!master_role_enable), .sck_in(serial_clock_pin_in), .din(sdo),
        .sck_out(far_sck), .dout(sdi), .got(far_got)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rx_valid === 1'b1) rx_cnt++;
        if (tx_underrun === 1'b1) ur_cnt++;
    end

    task automatic miss(input string what);
        error_cnt++;
        $display("MISMATCH t=%0t %s", $time, what);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) miss(what);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) miss(what);
    endtask
    task automatic chk_num(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp) miss(what);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // port held off while the mode changes, so pin muxing makes no stray edge
    task automatic setup(input logic m, input logic f, input logic s);
        @(negedge clk);
        port_enable = 1'b0;
        master_role_enable = m;
        framed_operation_enable = f;
        select_pin_function_enable = s;
        input_sample_phase = 1'b0;
        repeat (4) @(negedge clk);
        port_enable = 1'b1;
        repeat (16) @(negedge clk);
    endtask

    task automatic push(input logic [7:0] w);
        @(negedge clk);
        tx_data = w;
        tx_valid = 1'b1;
        n = 0;
        while (tx_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
    endtask

    task automatic wait_rx(input int base, input int lim);
        i = 0;
        while (rx_cnt <= base && i < lim) begin
            @(negedge clk);
            i++;
        end
    endtask

    task automatic t_master(input logic early);
        setup(1'b0, 1'b0, 1'b0);
        clk_half_div = early ? 8'h07 : 8'h03;
        input_sample_phase = early;
        far.load(8'h96);
        @(negedge clk);
        master_role_enable = 1'b1;
        input_sample_phase = 1'b1;
        push(8'h5A);
        u = rx_cnt;
        i = 0;
        while (busy !== 1'b1 && i < 50) begin
            @(negedge clk);
            i++;
        end
        chk_bit(tx_buffer_full, 1'b0, "buffer not emptied at start");
        chk_bit(serial_clock_pin_oe, 1'b1, "master clock not driven");
        wait_rx(u, 600);
        chk_byte(rx_data, 8'h96, "master received word");
        chk_byte(far_got, 8'h5A, "far end word");
        chk_num(int'(far.min_half), early ? 56 : 40, "clock half period");
        $display("test master early=%0b done", early);
    endtask

    task automatic t_framed(input logic pol);
        // polarity changes only once the sync pin is released
        @(negedge clk);
        port_enable = 1'b0;
        repeat (2) @(negedge clk);
        frame_sync_polarity = pol;
        clk_half_div = 8'h05;
        setup(1'b1, 1'b1, 1'b0);
        n = 0;
        u = 0;
        prev = serial_clock_pin_out;
        for (i = 0; i < 100; i++) begin
            @(negedge clk);
            if (serial_clock_pin_out !== prev) n++;
            if (slave_select_pin_out !== ~pol) u++;
            prev = serial_clock_pin_out;
        end
        chk_num(n, 20, "clock toggles between words");
        chk_num(u, 0, "sync not held inactive");
        chk_bit(slave_select_pin_oe, 1'b1, "sync pin not driven");
        push(8'hC9);
        i = 0;
        while (slave_select_pin_out !== pol && i < 200) begin
            @(negedge clk);
            i++;
        end
        n = 0;
        while (slave_select_pin_out === pol && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk_num(n, 10, "sync pulse length");
        $display("test framed pol=%0b done", pol);
    endtask

    task automatic t_slave(input logic f);
        setup(1'b0, f, 1'b0);
        // sync held active through each word when framed
        ss_drv = frame_sync_polarity;
        push(8'hA5);
        repeat (4) @(negedge clk);
        chk_bit(tx_buffer_full, 1'b1, "slave buffer not loaded");
        u = ur_cnt;
        n = rx_cnt;
        far.run_word(8'h3C);
        repeat (20) @(negedge clk);
        chk_num(rx_cnt - n, 1, "slave word count");
        chk_byte(rx_data, 8'h3C, "slave received word");
        chk_bit(tx_buffer_full, 1'b0, "slave buffer not emptied");
        chk_byte(far_got, 8'hA5, "slave sent word");
        // second word run with nothing pushed to refill the buffer, on purpose
        far.run_word(8'hC3);
        repeat (20) @(negedge clk);
        chk_num(ur_cnt - u, 1, "empty start not flagged");
        chk_byte(rx_data, 8'hC3, "slave second word");
        chk_byte(far_got, 8'h00, "empty buffer not sending zeros");
        $display("test slave framed=%0b done", f);
    endtask

    task automatic t_fill;
        setup(1'b0, 1'b1, 1'b1);
        chk_bit(config_error, 1'b1, "invalid pair not flagged");
        n = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            tx_data = i[7:0];
            tx_valid = 1'b1;
            if (tx_ready === 1'b1) n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
        chk_bit(tx_ready, 1'b0, "full fifo not refusing");
        chk_bit(busy, 1'b0, "halted port shifting");
        chk_num(n, 33, "words taken"); // fifo plus the one-word buffer
        u = rx_cnt;
        clk_half_div = 8'h03;
        setup(1'b1, 1'b0, 1'b0);
        wait_rx(u + n - 1, 6000);
        repeat (20) @(negedge clk);
        chk_num(rx_cnt - u, n, "words drained");
        chk_bit(tx_buffer_full, 1'b0, "buffer left full");
        chk_bit(tx_ready, 1'b1, "fifo not ready after drain");
        chk_byte(far_got, 8'h20, "last drained word");
        $display("test fill and drain done");
    endtask

    initial begin
        #400000;
        miss("watchdog expired");
        stop_test;
    end

    initial begin
        {rst_n, port_enable, master_role_enable, framed_operation_enable} = 4'h0;
        {select_pin_function_enable, input_sample_phase, frame_sync_polarity} = 3'h0;
        {clock_idle_polarity, tx_valid, ss_drv} = 3'h0;
        clk_half_div = 8'h05;
        tx_data = 8'h00;
        {error_cnt, checks_done, rx_cnt, ur_cnt} = '0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk_bit(serial_clock_pin_oe, 1'b0, "clock driven after reset");
        chk_bit(slave_select_pin_out, 1'b1, "select level after reset");
        chk_bit(tx_ready, 1'b1, "fifo not ready after reset");
        t_master(1'b1);
        t_master(1'b0);
        t_framed(1'b0);
        t_framed(1'b1);
        t_slave(1'b0);
        t_slave(1'b1);
        t_fill;
        stop_test;
    end
endmodule // tb_spi_frame_and_master_control
